// ---- pcs_cap_regs.sv ----
// pcs_cap_regs.sv: protocol capability bits and address fit registers
//
// Overview of operation
// - the multi-hop bit at 7 reads 1 only when aggregated groups can forward between each other.
// - the multi-hop bit reads 0 whenever the port bundling capability is 0.
// - the portal bit at 8 reads 1 only when a programmable service portal window exists.
// - with the portal bit at 1 the portal size register is present.
// - with the alignment bit at 9 clear, map windows use 4GB aligned start and end.
// - with the alignment bit set, a window start aligns to its power-of-two size.
// - under power-of-two alignment a window below 4GB counts as 4GB.
// - under power-of-two alignment an odd size rounds up, leaving a hole above.
// - with the alignment bit clear, table base addresses align to 4GB.
// - with the alignment bit set, table bases align to the rounded pool group size.
// - a pool group is a base-capable pool followed by fixed-offset pools.
// - reporting 0 in the alignment bit is the recommended choice.
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_cap_regs #(
    parameter logic        MULTI_HOP_CAP     = 1'b0,         // forwarding groups
    parameter logic        PORT_BUNDLING_CAP = 1'b0,         // aggregation capable
    parameter logic        PORTAL_CAP        = 1'b0,         // portal present
    parameter logic        ALIGN_MODE        = 1'b0,         // 1: power-of-two
    parameter logic [31:0] PORTAL_SIZE       = 32'h0000_0000 // portal size value
) (
    input  wire logic        clock_in,    // 100 MHz clock
    input  wire logic        sys_rst_in,  // sync reset, high
    input  wire logic        ce_in,       // clock enable
    input  wire logic [7:0]  addr_in,     // byte address
    input  wire logic [31:0] wr_data_in,  // write data
    input  wire logic        wr_in,       // write strobe
    input  wire logic        rd_in,       // read strobe
    output logic      [31:0] rd_data_out, // read data, next cycle
    output logic             win_ok_out,  // window fits rules
    output logic             pool_ok_out  // pool base fits rules
);
    // ==========================================
    // address decode
    function automatic logic pcs_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction : pcs_hit

    pcs_pkg::pcs_bus_req_t req;
    assign req.addr  = addr_in;
    assign req.wdata = wr_data_in;
    assign req.wr    = wr_in;
    assign req.rd    = rd_in;

    wire hit_cap    = pcs_hit(req.addr, `PCS_OFF_CAP);
    wire hit_psize  = pcs_hit(req.addr, `PCS_OFF_PSIZE);
    wire hit_wstart = pcs_hit(req.addr, `PCS_OFF_WSTART);
    wire hit_wsize  = pcs_hit(req.addr, `PCS_OFF_WSIZE);
    wire hit_wstat  = pcs_hit(req.addr, `PCS_OFF_WSTAT);
    wire hit_wspan  = pcs_hit(req.addr, `PCS_OFF_WSPAN);
    wire hit_pbase  = pcs_hit(req.addr, `PCS_OFF_PBASE);
    wire hit_pentry = pcs_hit(req.addr, `PCS_OFF_PENTRY);
    wire hit_pstat  = pcs_hit(req.addr, `PCS_OFF_PSTAT);
    wire hit_ptotal = pcs_hit(req.addr, `PCS_OFF_PTOTAL);

    // ==========================================
    // capability word
    // multi-hop is masked by bundling so a bad parameter set cannot leak
    wire       mhop_bit   = MULTI_HOP_CAP & PORT_BUNDLING_CAP;
    wire       portal_bit = PORTAL_CAP;
    wire       align_bit  = ALIGN_MODE;
    wire [31:0] cap_word;
    // reserved field stays zero, the word has no storage at all
    assign cap_word = ({31'h0, mhop_bit}   << `PCS_BIT_MHOP)
                    | ({31'h0, portal_bit} << `PCS_BIT_PORTAL)
                    | ({31'h0, align_bit}  << `PCS_BIT_ALIGN);
    // size register only exists when the portal does
    wire [31:0] psize_word = PORTAL_CAP ? PORTAL_SIZE : `PCS_RST_WORD;

    // ==========================================
    // software-written fit registers
    logic [31:0] win_start;
    logic [31:0] win_size;
    logic [31:0] pool_base;

    wire wr_ok      = ce_in && req.wr;
    wire entry_wr   = wr_ok && hit_pentry;

    // writes to the capability offset fall through untouched
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            win_start <= `PCS_RST_WORD;
            win_size  <= `PCS_RST_WORD;
            pool_base <= `PCS_RST_WORD;
        end else if (wr_ok) begin
            if (hit_wstart) win_start <= req.wdata;
            if (hit_wsize)  win_size  <= req.wdata;
            if (hit_pbase)  pool_base <= req.wdata;
        end
    end

    // ==========================================
    // checkers
    pcs_pkg::pcs_fit_t win_fit;
    pcs_pkg::pcs_fit_t pool_fit;
    logic [31:0]       pool_total;
    logic              pool_open;
    logic              pool_orphan;

    pcs_win_fit u_win (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .mode_in    (align_bit),
        .start_in   (win_start),
        .size_in    (win_size),
        .fit_out    (win_fit)
    );

    pcs_pool_fit u_pool (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .ce_in       (ce_in),
        .mode_in     (align_bit),
        .base_in     (pool_base),
        .entry_wr_in (entry_wr),
        .entry_in    (req.wdata),
        .total_out   (pool_total),
        .open_out    (pool_open),
        .orphan_out  (pool_orphan),
        .fit_out     (pool_fit)
    );

    assign win_ok_out  = win_fit.ok;
    assign pool_ok_out = pool_fit.ok;

    // ==========================================
    // read path
    wire [31:0] wstat_word = {29'h0, win_fit.ovf, win_fit.hole, win_fit.ok};
    wire [31:0] pstat_word = {27'h0, pool_orphan, pool_open,
                              pool_fit.ovf, pool_fit.hole, pool_fit.ok};
    wire [31:0] rd_mux;
    // unmapped offsets answer zero
    assign rd_mux = hit_cap    ? cap_word
                  : hit_psize  ? psize_word
                  : hit_wstart ? win_start
                  : hit_wsize  ? win_size
                  : hit_wstat  ? wstat_word
                  : hit_wspan  ? win_fit.span
                  : hit_pbase  ? pool_base
                  : hit_pstat  ? pstat_word
                  : hit_ptotal ? pool_total
                  : `PCS_RST_WORD;

    // data stands for one enabled cycle only, then zero; a low enable holds it
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rd_data_out <= `PCS_RST_WORD;
        end else if (ce_in) begin
            rd_data_out <= req.rd ? rd_mux : `PCS_RST_WORD;
        end
    end

    // ==========================================
    // assertions
    wire [30:0] entry_size = req.wdata[30:0];
    wire        entry_base = req.wdata[`PCS_ENTRY_BASE];

    sequence s_cap_read;
        ce_in && req.rd && hit_cap;
    endsequence

    sequence s_cap_write;
        ce_in && req.wr && hit_cap;
    endsequence

    sequence s_base_entry;
        ce_in && req.wr && hit_pentry && entry_base;
    endsequence

    sequence s_fixed_entry;
        ce_in && req.wr && hit_pentry && !entry_base;
    endsequence

    chk_mhop_value: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_read |=> rd_data_out[`PCS_BIT_MHOP]
                       == (MULTI_HOP_CAP && PORT_BUNDLING_CAP))
        else $error("multi-hop bit wrong");

    chk_mhop_needs_bundle: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_read ##1 !PORT_BUNDLING_CAP |-> !rd_data_out[`PCS_BIT_MHOP])
        else $error("multi-hop set without bundling");

    chk_portal_bit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_read |=> rd_data_out[`PCS_BIT_PORTAL] == PORTAL_CAP)
        else $error("portal bit wrong");

    chk_portal_size: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ce_in && req.rd && hit_psize
        |=> rd_data_out == (PORTAL_CAP ? PORTAL_SIZE : 32'h0000_0000))
        else $error("portal size read wrong");

    chk_align_bit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_read |=> rd_data_out[`PCS_BIT_ALIGN] == ALIGN_MODE)
        else $error("alignment bit wrong");

    chk_rsvd_zero: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_read |=> rd_data_out[`PCS_RSVD_HI:`PCS_RSVD_LO] == 4'h0)
        else $error("reserved bits not zero");

    chk_cap_write_ignored: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_cap_write ##1 s_cap_read |=> rd_data_out == cap_word
            && rd_data_out[31:`PCS_RSVD_HI+1] == 18'h0)
        else $error("capability word changed by write");

    chk_win_4g_fit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        !ALIGN_MODE && win_fit.ok && $past(ce_in)
        && $stable(win_start) && $stable(win_size)
        |-> win_start[`PCS_GRAN_4G-1:0] == 12'h000
            && win_size[`PCS_GRAN_4G-1:0] == 12'h000)
        else $error("window passed without 4GB alignment");

    chk_win_p2_fit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && win_fit.ok && !win_fit.ovf && $past(ce_in)
        && $stable(win_start) && $stable(win_size)
        |-> (win_start & (win_fit.span - 32'h0000_0001)) == 32'h0000_0000)
        else $error("window start not size aligned");

    chk_win_min_span: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && !win_fit.ovf && $past(ce_in && !sys_rst_in) && $stable(win_size)
        |-> win_fit.span >= 32'h0000_1000 && win_fit.span >= win_size)
        else $error("window span below 4GB or size");

    chk_win_pow2_hole: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && !win_fit.ovf && $past(ce_in && !sys_rst_in) && $stable(win_size)
        |-> $onehot(win_fit.span) && win_fit.hole == (win_fit.span != win_size))
        else $error("window span not rounded to power of two");

    chk_pool_4g_fit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        !ALIGN_MODE && pool_fit.ok && $past(ce_in) && $stable(pool_base)
        |-> pool_base[`PCS_GRAN_4G-1:0] == 12'h000)
        else $error("pool base passed without 4GB alignment");

    chk_pool_p2_fit: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && pool_fit.ok && !pool_fit.ovf && pool_fit.span != 32'h0
        && $past(ce_in) && $stable(pool_base) && $stable(pool_total)
        |-> (pool_base & (pool_fit.span - 32'h0000_0001)) == 32'h0000_0000)
        else $error("pool base not group aligned");

    chk_pool_group_sum: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_base_entry ##1 s_fixed_entry
        |=> pool_open && pool_total
            == {1'b0, $past(entry_size, 2)} + {1'b0, $past(entry_size)})
        else $error("pool group total wrong");

    chk_pool_orphan: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_fixed_entry and !pool_open |=> pool_orphan && !pool_open)
        else $error("fixed pool without base not flagged");

    chk_rd_idle_zero: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ce_in && !req.rd |=> rd_data_out == 32'h0000_0000)
        else $error("read data outside answer cycle");

    chk_pool_base_open: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        s_base_entry |=> pool_open && !pool_orphan
            && pool_total == {1'b0, $past(entry_size)})
        else $error("base pool did not open a group");

    chk_win_small_round: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && $past(ce_in && !sys_rst_in) && $stable(win_size)
        && win_size < 32'h0000_1000
        |-> win_fit.span == 32'h0000_1000 && win_fit.hole)
        else $error("small window not rounded to 4GB");

    chk_win_4g_span: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        !ALIGN_MODE && $past(ce_in && !sys_rst_in) && $stable(win_size)
        |-> win_fit.span == win_size && !win_fit.hole && !win_fit.ovf)
        else $error("4GB mode window span altered");

    chk_pool_pow2_hole: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        ALIGN_MODE && pool_total != 32'h0000_0000 && $past(ce_in && !sys_rst_in)
        && $stable(pool_total) && !pool_fit.ovf
        |-> $onehot(pool_fit.span) && pool_fit.span >= pool_total
            && pool_fit.hole == (pool_fit.span != pool_total))
        else $error("pool span not rounded to power of two");

    // a low enable must hold every visible result, reset aside
    chk_ce_freeze: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        !ce_in |=> $stable(rd_data_out) && $stable(win_ok_out) && $stable(pool_ok_out))
        else $error("state moved while clock enable low");
endmodule : pcs_cap_regs

// ---- pcs_cfg.svh ----
// pcs_cfg.svh: register offsets, field positions and reset values
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ==========================================
// register byte offsets
`define PCS_ADDR_W      8
`define PCS_OFF_CAP     8'h00
`define PCS_OFF_PSIZE   8'h04
`define PCS_OFF_WSTART  8'h08
`define PCS_OFF_WSIZE   8'h0C
`define PCS_OFF_WSTAT   8'h10
`define PCS_OFF_WSPAN   8'h14
`define PCS_OFF_PBASE   8'h18
`define PCS_OFF_PENTRY  8'h1C
`define PCS_OFF_PSTAT   8'h20
`define PCS_OFF_PTOTAL  8'h24

// ==========================================
// field positions
`define PCS_BIT_MHOP    7
`define PCS_BIT_PORTAL  8
`define PCS_BIT_ALIGN   9
`define PCS_RSVD_HI     13
`define PCS_RSVD_LO     10
`define PCS_ENTRY_BASE  31
`define PCS_ST_OK       0
`define PCS_ST_HOLE     1
`define PCS_ST_OVF      2
`define PCS_ST_OPEN     3
`define PCS_ST_ORPHAN   4

// ==========================================
// granules: values count 1MB units, 4GB is 2^12 of them
`define PCS_GRAN_4G     12
`define PCS_MIN_SPAN    33'h0_0000_1000
`define PCS_RST_WORD    32'h0000_0000

`endif

// ---- pcs_pkg.sv ----
// pcs_pkg.sv: carrier types and shared arithmetic
package pcs_pkg;

    // ==========================================
    // types
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcs_bus_req_t;

    typedef struct packed {
        logic        ok;
        logic        hole;
        logic        ovf;
        logic [31:0] span;
    } pcs_fit_t;

    // ==========================================
    // smallest power of two not below x, zero for x of zero
    function automatic logic [32:0] pcs_pow2_ceil(input logic [31:0] x);
        logic [32:0] v;
        v = {1'b0, x} - 33'h0_0000_0001;
        for (int i = 1; i < 33; i = i * 2) begin
            v = v | (v >> i);
        end
        return v + 33'h0_0000_0001;
    endfunction : pcs_pow2_ceil

endpackage : pcs_pkg

// ---- pcs_pool_fit.sv ----
// pcs_pool_fit.sv: memory pool group tracking and base alignment check
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_pool_fit (
    input  wire logic             clock_in,    // core clock
    input  wire logic             sys_rst_in,  // sync reset
    input  wire logic             ce_in,       // clock enable
    input  wire logic             mode_in,     // 1: power-of-two
    input  wire logic [31:0]      base_in,     // table base, MB units
    input  wire logic             entry_wr_in, // pool entry strobe
    input  wire logic [31:0]      entry_in,    // cap bit and size
    output logic      [31:0]      total_out,   // group size
    output logic                  open_out,    // group in progress
    output logic                  orphan_out,  // fixed pool, no base
    output pcs_pkg::pcs_fit_t     fit_out      // registered result
);
    // ==========================================
    // group accumulation
    wire                is_base = entry_in[`PCS_ENTRY_BASE];
    wire [32:0]         sum     = {1'b0, total_out}
                                  + {2'b00, entry_in[30:0]};
    wire [31:0]         sat     = sum[32] ? '1 : sum[31:0];
    wire [32:0]         p2      = pcs_pkg::pcs_pow2_ceil(total_out);
    wire [32:0]         msk     = (p2 == 33'h0) ? 33'h0
                                  : p2 - 33'h0_0000_0001;
    pcs_pkg::pcs_fit_t  next_fit;

    // a base-capable pool opens a run, fixed-offset pools extend it
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            total_out  <= '0;
            open_out   <= 1'b0;
            orphan_out <= 1'b0;
        end else if (ce_in && entry_wr_in) begin
            if (is_base) begin
                total_out  <= {1'b0, entry_in[30:0]};
                open_out   <= 1'b1;
                orphan_out <= 1'b0;
            end else if (open_out) begin
                total_out  <= sat;
            end else begin
                orphan_out <= 1'b1;
            end
        end
    end

    // base alignment per mode, holes above odd sizes
    always_comb begin
        next_fit.ok   = mode_in ? (({1'b0, base_in} & msk) == 33'h0)
                        : (base_in[`PCS_GRAN_4G-1:0] == '0);
        next_fit.hole = mode_in && (p2 != {1'b0, total_out});
        next_fit.ovf  = mode_in && p2[32];
        next_fit.span = mode_in ? p2[31:0] : total_out;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fit_out <= '0;
        end else if (ce_in) begin
            fit_out <= next_fit;
        end
    end
endmodule : pcs_pool_fit

// ---- pcs_win_fit.sv ----
// pcs_win_fit.sv: address map window alignment and rounding check
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_win_fit (
    input  wire logic             clock_in,   // core clock
    input  wire logic             sys_rst_in, // sync reset
    input  wire logic             ce_in,      // clock enable
    input  wire logic             mode_in,    // 1: power-of-two
    input  wire logic [31:0]      start_in,   // start, MB units
    input  wire logic [31:0]      size_in,    // size, MB units
    output pcs_pkg::pcs_fit_t     fit_out     // registered result
);
    // ==========================================
    // rounding
    wire [32:0]         p2     = pcs_pkg::pcs_pow2_ceil(size_in);
    wire                below_4g = p2 < `PCS_MIN_SPAN;
    wire [32:0]         eff    = below_4g ? `PCS_MIN_SPAN : p2;
    wire [32:0]         msk    = eff - 33'h0_0000_0001;
    wire                al_p2  = ({1'b0, start_in} & msk) == 33'h0;
    wire                al_4g  = (start_in[`PCS_GRAN_4G-1:0] == '0)
                                 && (size_in[`PCS_GRAN_4G-1:0] == '0);
    pcs_pkg::pcs_fit_t  next_fit;

    // space above the real size becomes a hole
    always_comb begin
        next_fit.ok   = mode_in ? al_p2 : al_4g;
        next_fit.hole = mode_in && (eff != {1'b0, size_in});
        next_fit.ovf  = mode_in && eff[32];
        next_fit.span = mode_in ? eff[31:0] : size_in;
    end

    // result follows the registers one cycle later
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fit_out <= '0;
        end else if (ce_in) begin
            fit_out <= next_fit;
        end
    end
endmodule : pcs_win_fit

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for the capability and fit registers
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module tb_top;
    // ==========================================
    // drive, observe and bench-side pool model
    logic        clock_in    = 1'b0;
    logic        sys_rst_in  = 1'b1;
    logic        ce_in       = 1'b1;
    logic [7:0]  addr_in     = 8'h00;
    logic [31:0] wr_data_in  = 32'h0000_0000;
    logic        wr_in       = 1'b0;
    logic        rd_in       = 1'b0;
    logic [31:0] rd_a, rd_b, got_a, got_b;
    logic        wok_a, wok_b, pok_a, pok_b;
    logic [31:0] p_total     = 32'h0000_0000;
    logic [31:0] p_base      = 32'h0000_0000;
    logic        p_open      = 1'b0;
    logic        p_orphan    = 1'b0;
    int          fails       = 0;
    int          comparisons = 0;

    // unit a: every capability set; unit b: all defaults, recommended alignment
    pcs_cap_regs #(.MULTI_HOP_CAP(1'b1), .PORT_BUNDLING_CAP(1'b1), .PORTAL_CAP(1'b1),
        .ALIGN_MODE(1'b1), .PORTAL_SIZE(32'h0000_0040)) uut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_a),
        .win_ok_out(wok_a), .pool_ok_out(pok_a));
    pcs_cap_regs uut_zero (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_b),
        .win_ok_out(wok_b), .pool_ok_out(pok_b));

    // ==========================================
    // clock, compare and bus tasks
    always #5 clock_in = ~clock_in;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    // with more set the strobe stays up, so the next call follows with no gap
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input bit more = 1'b0);
        @(posedge clock_in);
        wr_in      <= 1'b1;
        addr_in    <= a;
        wr_data_in <= d;
        if (!more) begin
            @(posedge clock_in);
            wr_in <= 1'b0;
        end
    endtask : bus_write

    // read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read(input logic [7:0] a);
        @(posedge clock_in);
        rd_in   <= 1'b1;
        wr_in   <= 1'b0;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        got_a = rd_a;
        got_b = rd_b;
    endtask : bus_read

    // ==========================================
    // expectations: sizes in 1MB units, 4GB is 0x1000 of them
    function automatic logic [32:0] ceil2(input logic [31:0] x);
        logic [32:0] p;
        p = 33'h0_0000_0001;
        while (p < {1'b0, x}) p = p << 1;
        return p;
    endfunction : ceil2

    function automatic logic [31:0] win_stat(input logic m, input logic [31:0] st,
                                             input logic [31:0] sz, output logic [31:0] sp);
        logic [32:0] span;
        sp = sz;
        if (!m) return {31'h0, (st[11:0] == 12'h000) && (sz[11:0] == 12'h000)};
        span = ceil2(sz);
        if (span < 33'h0_0000_1000) span = 33'h0_0000_1000;
        sp = span[31:0];
        return {29'h0, span[32], span[31:0] != sz, ({1'b0, st} % span) == 33'h0};
    endfunction : win_stat

    function automatic logic [31:0] pool_stat(input logic m);
        logic [32:0] span;
        span = ceil2(p_total);
        if (!m) return {27'h0, p_orphan, p_open, 2'b00, p_base[11:0] == 12'h000};
        return {27'h0, p_orphan, p_open, span[32], (p_total != 32'h0) && (span[31:0] != p_total),
                ({1'b0, p_base} % span) == 33'h0};
    endfunction : pool_stat

    // ==========================================
    // scenario tasks
    task automatic win_case(input logic [31:0] st, input logic [31:0] sz);
        logic [31:0] ea, eb, sa, sb;
        ea = win_stat(1'b1, st, sz, sa);
        eb = win_stat(1'b0, st, sz, sb);
        bus_write(`PCS_OFF_WSTART, st);
        bus_write(`PCS_OFF_WSIZE, sz);
        repeat (2) @(posedge clock_in);
        bus_read(`PCS_OFF_WSTAT);
        check(got_a, ea);
        check(got_b, eb);
        check({31'h0, wok_a}, {31'h0, ea[0]});
        check({31'h0, wok_b}, {31'h0, eb[0]});
        bus_read(`PCS_OFF_WSPAN);
        check(got_a, sa);
        check(got_b, sb);
    endtask : win_case

    task automatic pool_entry(input logic basecap, input logic [30:0] sz, input bit more = 1'b0);
        bus_write(`PCS_OFF_PENTRY, {basecap, sz}, more);
        if (basecap) begin
            p_total  = {1'b0, sz};
            p_open   = 1'b1;
            p_orphan = 1'b0;
        end else if (p_open) begin
            p_total = p_total + {1'b0, sz};
        end else begin
            p_orphan = 1'b1;
        end
    endtask : pool_entry

    // total lands one edge after the entry, the fit one edge later
    task automatic pool_check;
        logic [31:0] ea, eb;
        ea = pool_stat(1'b1);
        eb = pool_stat(1'b0);
        repeat (3) @(posedge clock_in);
        bus_read(`PCS_OFF_PSTAT);
        check(got_a, ea);
        check(got_b, eb);
        check({31'h0, pok_a}, {31'h0, ea[0]});
        check({31'h0, pok_b}, {31'h0, eb[0]});
        bus_read(`PCS_OFF_PTOTAL);
        check(got_a, p_total);
    endtask : pool_check

    task automatic close_out;
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ==========================================
    // main sequence
    logic [31:0] cs [6] = '{32'h0, 32'h1000, 32'h2000, 32'h800, 32'h8000_0000, 32'h4_0000};
    logic [31:0] cz [6] = '{32'h0, 32'h1000, 32'h3000, 32'h400, 32'h8000_0000, 32'h2_0001};

    initial begin
        logic [31:0] s, z;
        void'($urandom(2));
        repeat (6) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        bus_read(`PCS_OFF_CAP);
        check(got_a, 32'h0000_0380);
        check(got_b, 32'h0000_0000);
        bus_read(`PCS_OFF_PSIZE);
        check(got_a, 32'h0000_0040);
        check(got_b, 32'h0000_0000);
        // writes to read-only words must bounce off, back to back
        bus_write(`PCS_OFF_PSIZE, 32'hFFFF_FFFF, 1'b1);
        bus_write(`PCS_OFF_CAP, 32'hFFFF_FFFF, 1'b1);
        bus_read(`PCS_OFF_CAP);
        check(got_a, 32'h0000_0380);
        check(got_b, 32'h0000_0000);
        bus_read(`PCS_OFF_PSIZE);
        check(got_a, 32'h0000_0040);
        bus_read(8'h40);
        check(got_a, 32'h0000_0000);
        // strobes while the clock enable is low are ignored
        @(posedge clock_in);
        ce_in <= 1'b0;
        bus_write(`PCS_OFF_WSTART, 32'h1234_5000);
        ce_in <= 1'b1;
        bus_read(`PCS_OFF_WSTART);
        check(got_a, 32'h0000_0000);
        // hand-picked windows, then random ones
        for (int i = 0; i < 6; i++) win_case(cs[i], cz[i]);
        for (int i = 0; i < 24; i++) begin
            z = ($urandom & 32'h3FFF_FFFF) >> $urandom_range(0, 20);
            if (i % 3 == 0) z = 32'h0000_1000 << $urandom_range(0, 4);
            s = $urandom & ~((32'h1 << $urandom_range(8, 31)) - 32'h1);
            win_case(s, z);
        end
        // a fixed-offset pool with no base pool ahead of it
        pool_entry(1'b0, 31'h100);
        pool_check;
        p_base = 32'h0000_0400;
        bus_write(`PCS_OFF_PBASE, p_base);
        pool_entry(1'b1, 31'h200, 1'b1);
        pool_entry(1'b0, 31'h100);
        pool_check;
        pool_entry(1'b0, 31'h100);
        pool_check;
        for (int i = 0; i < 8; i++) begin
            p_base = $urandom & ~((32'h1 << $urandom_range(4, 20)) - 32'h1);
            bus_write(`PCS_OFF_PBASE, p_base);
            pool_entry(1'b1, 31'($urandom_range(1, 32'h3000)));
            repeat ($urandom_range(0, 3)) pool_entry(1'b0, 31'($urandom_range(1, 32'h3000)));
            pool_check;
        end
        // second reset in mid-run clears every writable word
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        p_total  = 32'h0000_0000;
        p_base   = 32'h0000_0000;
        p_open   = 1'b0;
        p_orphan = 1'b0;
        bus_read(`PCS_OFF_WSTART);
        check(got_a, 32'h0000_0000);
        pool_check;
        close_out();
    end

    // watchdog: the whole sequence needs well under 5,000 cycles
    initial begin
        #200000;
        fails++;
        close_out();
    end
endmodule : tb_top
